// *** hw/sel_pkg.sv ***
/*
  Package for the secondary error log register bank: offsets, field
  positions, reset values and error class positions.
  Assumes a config-space read port word-addressed by byte offset.
*/
package sel_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses in extended config space)
  // ---------------------------------------------------------------
  localparam logic [11:0] SEL_OFS_CAP_CTRL = 12'h138;
  localparam logic [11:0] SEL_OFS_HLOG_DW0 = 12'h13c;
  localparam logic [11:0] SEL_OFS_HLOG_DW1 = 12'h140;
  localparam logic [11:0] SEL_OFS_HLOG_DW2 = 12'h144;
  localparam logic [11:0] SEL_OFS_HLOG_DW3 = 12'h148;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int SEL_FIRST_ERR_W = 5;
  localparam int SEL_LOWER_CMD_LSB = 36;
  localparam int SEL_UPPER_CMD_LSB = 40;
  localparam logic [4:0] SEL_FIRST_ERR_RST = 5'h00;
  localparam logic [31:0] SEL_WORD_RST = 32'h0000_0000;
  localparam logic [3:0] SEL_CMD_RST = 4'h0;
  // error class bit positions in the uncorrectable status register
  localparam logic [4:0] SEL_CLASS_MASTER_ABORT = 5'h03;
  localparam logic [4:0] SEL_CLASS_TARGET_ABORT = 5'h02;
  localparam int SEL_NUM_WORDS = 4;
endpackage : sel_pkg

// *** hw/sel_sync3.sv ***
/*
  Three-flop input synchroniser with agreement filter.
  Assumes a single clock; input comes from a foreign domain or pin.
*/
`timescale 1ns/10ps
`default_nettype none
module sel_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  // -------------------------------------------------------------
  // filter: change counts once stages two and three agree
  // -------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  // first stage is read only by the second
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_o = out_ff;
endmodule : sel_sync3
`default_nettype wire

// *** hw/sel_regs.sv ***
/*
  Secondary error log registers: first error index and 128-bit header
  log of the PCI cycle that caused the latest secondary error.
  Assumes the PCI master/target logic reports error events with the
  captured address phases and command lines on the same clock, and a
  reset controller that presents the three reset classes as levels
  from outside this clock domain.
*/
//
// Behaviour
// - A five-bit first error index holds the status bit position of the first error class.
// - Each secondary error captures the address and command of its PCI cycle into the log.
// - The log reads as four words at 13Ch..148h, low word first.
// - First address phase goes to log bits 95:64, second to 127:96.
// - A single-address cycle logs zero in bits 127:96.
// - Dual-address cycles log the second phase command lines in bits 43:40.
// - First phase command lines go to log bits 39:36.
// - Attribute bits 35:0 always read zero.
// - Reserved bits 63:44 of the log and 31:5 of the control register read zero.
// - Sticky bits clear only on global or power-on reset.
// - Index, address and command clear on fundamental, global or power-on reset.
// - Unmarked bits also clear on hot reset.
// - Master abort sets class 3 and target abort class 2 as index candidates.
`timescale 1ns/10ps
`default_nettype none
module sel_regs
  import sel_pkg::*;
(
  // clock and power-on reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // other reset classes, asynchronous levels, active high
  input wire logic global_reset_input_i,
  input wire logic fund_reset_i,
  input wire logic hot_reset_i,
  // error events from the secondary PCI master
  input wire logic master_abort_i,
  input wire logic target_abort_i,
  // cycle capture from the secondary PCI interface
  input wire logic [31:0] addr_phase1_i,
  input wire logic [31:0] addr_phase2_i,
  input wire logic [3:0] cmd_phase1_i,
  input wire logic [3:0] cmd_phase2_i,
  input wire logic dual_addr_i,
  // first error already pending in the status register
  input wire logic first_err_hold_i,
  // configuration read port
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o
);
  // -------------------------------------------------------------
  // reset synchronisation
  // -------------------------------------------------------------
  logic fund_rst_s, glob_rst_s;
  logic [1:0] rst_sync;

  sel_sync3 #(.W(2)) u_rst_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i({global_reset_input_i, fund_reset_i}),
    .sync_o(rst_sync)
  );
  assign glob_rst_s = rst_sync[1];
  assign fund_rst_s = rst_sync[0];

  // hot reset class has no bits here, since every field is marked;
  // kept as a port so the reset fabric is uniform
  logic hot_unused;
  assign hot_unused = hot_reset_i;

  // -------------------------------------------------------------
  // log state
  // -------------------------------------------------------------
  logic [SEL_FIRST_ERR_W-1:0] first_err_ff, nxt_first_err;
  logic first_valid_ff, nxt_first_valid;
  logic [31:0] addr_lo_ff, nxt_addr_lo;
  logic [31:0] addr_hi_ff, nxt_addr_hi;
  logic [3:0] cmd_lo_ff, nxt_cmd_lo;
  logic [3:0] cmd_hi_ff, nxt_cmd_hi;
  logic err_event;
  logic clr_marked;

  assign err_event = master_abort_i | target_abort_i;
  assign clr_marked = fund_rst_s | glob_rst_s;

  // capture and clear; software writes are never looked at
  always_comb begin
    nxt_first_err = first_err_ff;
    nxt_first_valid = first_valid_ff;
    nxt_addr_lo = addr_lo_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_cmd_lo = cmd_lo_ff;
    nxt_cmd_hi = cmd_hi_ff;
    if (clr_marked) begin
      nxt_first_err = SEL_FIRST_ERR_RST;
      nxt_first_valid = 1'b0;
      nxt_addr_lo = SEL_WORD_RST;
      nxt_addr_hi = SEL_WORD_RST;
      nxt_cmd_lo = SEL_CMD_RST;
      nxt_cmd_hi = SEL_CMD_RST;
    end else if (err_event) begin
      // first error kept until the status bit is cleared
      if (!first_valid_ff || !first_err_hold_i) begin
        // master abort wins when both arrive together
        nxt_first_err = master_abort_i ? SEL_CLASS_MASTER_ABORT
                                       : SEL_CLASS_TARGET_ABORT;
        nxt_first_valid = 1'b1;
      end
      nxt_addr_lo = addr_phase1_i;
      nxt_addr_hi = dual_addr_i ? addr_phase2_i : SEL_WORD_RST;
      nxt_cmd_lo = cmd_phase1_i;
      nxt_cmd_hi = dual_addr_i ? cmd_phase2_i : SEL_CMD_RST;
    end else if (!first_err_hold_i) begin
      nxt_first_valid = 1'b0;
    end
  end

  // power-on reset clears everything; no sticky fields exist here
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_err_ff <= SEL_FIRST_ERR_RST;
      first_valid_ff <= 1'b0;
      addr_lo_ff <= SEL_WORD_RST;
      addr_hi_ff <= SEL_WORD_RST;
      cmd_lo_ff <= SEL_CMD_RST;
      cmd_hi_ff <= SEL_CMD_RST;
    end else begin
      first_err_ff <= nxt_first_err;
      first_valid_ff <= nxt_first_valid;
      addr_lo_ff <= nxt_addr_lo;
      addr_hi_ff <= nxt_addr_hi;
      cmd_lo_ff <= nxt_cmd_lo;
      cmd_hi_ff <= nxt_cmd_hi;
    end
  end

  // -------------------------------------------------------------
  // read decode
  // -------------------------------------------------------------
  logic [31:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic wr_unused;
  assign wr_unused = cfg_wr_i | (|cfg_wdata_i);

  function automatic logic [31:0] sel_word1(input logic [3:0] lo, input logic [3:0] hi);
    logic [31:0] w;
    w = '0;
    w[SEL_LOWER_CMD_LSB-32 +: 4] = lo;
    w[SEL_UPPER_CMD_LSB-32 +: 4] = hi;
    return w;
  endfunction : sel_word1

  // unmapped offsets read zero; one cycle of latency
  always_comb begin
    nxt_rvalid = cfg_rd_i;
    nxt_rdata = SEL_WORD_RST;
    if (cfg_rd_i) begin
      unique case (cfg_addr_i)
        SEL_OFS_CAP_CTRL: nxt_rdata = {27'h0, first_err_ff};
        SEL_OFS_HLOG_DW0: nxt_rdata = SEL_WORD_RST;
        SEL_OFS_HLOG_DW1: nxt_rdata = sel_word1(cmd_lo_ff, cmd_hi_ff);
        SEL_OFS_HLOG_DW2: nxt_rdata = addr_lo_ff;
        SEL_OFS_HLOG_DW3: nxt_rdata = addr_hi_ff;
        default: nxt_rdata = SEL_WORD_RST;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= SEL_WORD_RST;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign cfg_rdata_o = rdata_ff;
  assign cfg_rvalid_o = rvalid_ff;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_rd_cap;
    @(posedge core_clk_i) disable iff (reset_i)
    cfg_rd_i && cfg_addr_i == SEL_OFS_CAP_CTRL |=> cfg_rdata_o[31:5] == 27'h0;
  endproperty
  a_rd_cap: assert property (p_rd_cap) else $error("reserved bits nonzero");

  property p_attr_zero;
    @(posedge core_clk_i) disable iff (reset_i)
    cfg_rd_i && cfg_addr_i == SEL_OFS_HLOG_DW0 |=> cfg_rdata_o == 32'h0000_0000;
  endproperty
  a_attr_zero: assert property (p_attr_zero) else $error("attribute word nonzero");

  property p_cap_addr;
    @(posedge core_clk_i) disable iff (reset_i || clr_marked)
    err_event |=> addr_lo_ff == $past(addr_phase1_i);
  endproperty
  a_cap_addr: assert property (p_cap_addr) else $error("phase one not logged");

  property p_single_zero;
    @(posedge core_clk_i) disable iff (reset_i || clr_marked)
    err_event && !dual_addr_i |=> addr_hi_ff == 32'h0000_0000 && cmd_hi_ff == 4'h0;
  endproperty
  a_single_zero: assert property (p_single_zero) else $error("upper log not zero");

  property p_dual;
    @(posedge core_clk_i) disable iff (reset_i || clr_marked)
    err_event && dual_addr_i |=> cmd_hi_ff == $past(cmd_phase2_i)
      && addr_hi_ff == $past(addr_phase2_i);
  endproperty
  a_dual: assert property (p_dual) else $error("dual phase not logged");

  property p_cmd_lo;
    @(posedge core_clk_i) disable iff (reset_i || clr_marked)
    err_event |=> cmd_lo_ff == $past(cmd_phase1_i);
  endproperty
  a_cmd_lo: assert property (p_cmd_lo) else $error("lower command not logged");

  property p_clear;
    @(posedge core_clk_i) disable iff (reset_i)
    clr_marked |=> first_err_ff == 5'h00 && addr_lo_ff == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("marked bits not cleared");

  property p_stable;
    @(posedge core_clk_i) disable iff (reset_i)
    !err_event && !clr_marked |=> $stable(addr_lo_ff) && $stable(first_err_ff);
  endproperty
  a_stable: assert property (p_stable) else $error("log changed without cause");

  property p_class;
    @(posedge core_clk_i) disable iff (reset_i || clr_marked)
    master_abort_i && !first_valid_ff |=> first_err_ff == 5'h03;
  endproperty
  a_class: assert property (p_class) else $error("master abort class wrong");

  c_dual: cover property (@(posedge core_clk_i) err_event && dual_addr_i);
  c_single: cover property (@(posedge core_clk_i) err_event && !dual_addr_i);
  c_clear: cover property (@(posedge core_clk_i) clr_marked ##1 cfg_rd_i);
endmodule : sel_regs
`default_nettype wire

// *** dv/sel_pci_agent.sv ***
/*
  Secondary PCI agent model: produces one aborted cycle at a time.
  Assumes the bench calls abort() and nothing else drives these lines.
*/
`timescale 1ns/10ps
`default_nettype none
module sel_pci_agent (
  // clock
  input wire logic core_clk_i,
  // failing cycle towards the log
  output logic master_abort_o,
  output logic target_abort_o,
  output logic [31:0] addr1_o,
  output logic [31:0] addr2_o,
  output logic [3:0] cmd1_o,
  output logic [3:0] cmd2_o,
  output logic dual_o
);
  // quiet start
  initial begin
    {master_abort_o, target_abort_o, addr1_o, addr2_o, cmd1_o, cmd2_o, dual_o} = '0;
  end
  // lines valid only for the pulse; after it the abort strobes clear and the other lines flip so stale data never matches
  task automatic abort(input logic mst, input logic dac, input logic [31:0] a1,
                       input logic [31:0] a2, input logic [3:0] c1, input logic [3:0] c2);
    @(negedge core_clk_i);
    {master_abort_o, target_abort_o, dual_o} = {mst, !mst, dac};
    {addr1_o, addr2_o, cmd1_o, cmd2_o} = {a1, a2, c1, c2};
    @(negedge core_clk_i);
    {master_abort_o, target_abort_o} = 2'b00;
    {addr1_o, addr2_o, cmd1_o, cmd2_o, dual_o} = ~{addr1_o, addr2_o, cmd1_o, cmd2_o, dual_o};
  endtask : abort
endmodule : sel_pci_agent
`default_nettype wire

// *** dv/tb_secondary_error_log_regs.sv ***
/*
  Bench for the secondary error log registers: aborts, reads, writes, resets.
  Assumes sel_regs and the agent model; inputs change on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_secondary_error_log_regs
  import sel_pkg::*;
;
  logic clk, rst, global_reset_input, frst, hrst, hold, rd, wr;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic rvalid, mab, tab, dac;
  logic [31:0] a1, a2;
  logic [3:0] c1, c2;
  int n_fail = 0;
  int comparisons = 0;
  // ---------------------------------------------------------------
  // design and agent
  // ---------------------------------------------------------------
  sel_regs dut_u (.core_clk_i(clk), .reset_i(rst), .global_reset_input_i(global_reset_input),
    .fund_reset_i(frst), .hot_reset_i(hrst), .master_abort_i(mab), .target_abort_i(tab),
    .addr_phase1_i(a1), .addr_phase2_i(a2), .cmd_phase1_i(c1), .cmd_phase2_i(c2),
    .dual_addr_i(dac), .first_err_hold_i(hold), .cfg_rd_i(rd), .cfg_wr_i(wr),
    .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid));
  sel_pci_agent agent_u (.core_clk_i(clk), .master_abort_o(mab), .target_abort_o(tab),
    .addr1_o(a1), .addr2_o(a2), .cmd1_o(c1), .cmd2_o(c2), .dual_o(dac));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // read strobe one cycle; answer waited for under a bound
  task automatic cfg_read(input logic [11:0] a, input logic [31:0] exp);
    int i;
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    i = 0;
    while (rvalid !== 1'b1 && i < 4) begin
      @(negedge clk);
      i++;
    end
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask : cfg_read
  task automatic read_all(input logic [4:0] idx, input logic [31:0] w1, w2, w3);
    cfg_read(SEL_OFS_CAP_CTRL, {27'h0, idx});
    cfg_read(SEL_OFS_HLOG_DW0, SEL_WORD_RST);
    cfg_read(SEL_OFS_HLOG_DW1, w1);
    cfg_read(SEL_OFS_HLOG_DW2, w2);
    cfg_read(SEL_OFS_HLOG_DW3, w3);
  endtask : read_all
  function automatic logic [31:0] cmd_word(input logic [3:0] lo, input logic [3:0] up);
    return {20'h0, up, lo, 4'h0};
  endfunction : cmd_word
  // which: 0 global, 1 fundamental, 2 hot; long enough for the synchroniser
  task automatic rst_pulse(input int which);
    @(negedge clk);
    {global_reset_input, frst, hrst} = 3'b100 >> which;
    repeat (8) @(negedge clk);
    {global_reset_input, frst, hrst} = 3'b000;
    repeat (8) @(negedge clk);
  endtask : rst_pulse
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_dual_then_write();
    int k;
    // status bit stays pending from this abort on, so the index must freeze
    hold = 1'b1;
    agent_u.abort(1'b1, 1'b1, 32'h8000_1234, 32'h0000_00fe, 4'hd, 4'h7);
    read_all(SEL_CLASS_MASTER_ABORT, cmd_word(4'hd, 4'h7), 32'h8000_1234, 32'hfe);
    // writes must bounce off every word
    for (k = 0; k < 5; k++) begin
      @(negedge clk);
      {wr, addr, wdata} = {1'b1, SEL_OFS_CAP_CTRL + 12'(4 * k), 32'hffff_ffff};
      @(negedge clk);
      wr = 1'b0;
    end
    read_all(SEL_CLASS_MASTER_ABORT, cmd_word(4'hd, 4'h7), 32'h8000_1234, 32'hfe);
  endtask : t_dual_then_write
  task automatic t_single_latest();
    hold = 1'b1;
    agent_u.abort(1'b0, 1'b0, 32'h0bad_0c00, 32'h5555_aaaa, 4'h6, 4'h0);
    read_all(SEL_CLASS_MASTER_ABORT, cmd_word(4'h6, 4'h0), 32'h0bad_0c00, 32'h0);
    hold = 1'b0;
    agent_u.abort(1'b0, 1'b1, 32'h1, 32'hffff_ffff, 4'h7, 4'hf);
    read_all(SEL_CLASS_TARGET_ABORT, cmd_word(4'h7, 4'hf), 32'h1, 32'hffff_ffff);
  endtask : t_single_latest
  task automatic t_resets();
    rst_pulse(2);
    read_all(SEL_CLASS_TARGET_ABORT, cmd_word(4'h7, 4'hf), 32'h1, 32'hffff_ffff);
    rst_pulse(1);
    read_all(SEL_FIRST_ERR_RST, SEL_WORD_RST, SEL_WORD_RST, SEL_WORD_RST);
    agent_u.abort(1'b1, 1'b1, 32'h2, 32'h3, 4'hd, 4'h6);
    read_all(SEL_CLASS_MASTER_ABORT, cmd_word(4'hd, 4'h6), 32'h2, 32'h3);
    rst_pulse(0);
    read_all(SEL_FIRST_ERR_RST, SEL_WORD_RST, SEL_WORD_RST, SEL_WORD_RST);
  endtask : t_resets
  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // roughly twenty times the expected run
  initial begin
    #(40 * 4000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {rst, global_reset_input, frst, hrst, hold, rd, wr, addr, wdata} = {1'b1, 6'h0, 12'h0, 32'h0};
    repeat (16) @(negedge clk);
    rst = 1'b0;
    read_all(SEL_FIRST_ERR_RST, SEL_WORD_RST, SEL_WORD_RST, SEL_WORD_RST);
    cfg_read(12'h14c, SEL_WORD_RST);
    t_dual_then_write();
    t_single_latest();
    t_resets();
    tally_and_finish();
  end
endmodule : tb_secondary_error_log_regs
`default_nettype wire
